// ===== pkg/mem_decode_pkg.sv
`default_nettype none
package mem_decode_pkg;

    // ========================================
    // Register map (byte addresses)
    localparam logic [3:0] reg_decode_enable = 4'h0;
    localparam logic [3:0] reg_patch_enable = 4'h4;
    localparam logic [3:0] reg_timer_select = 4'h8;
    localparam logic [3:0] reg_top_swap = 4'hC;
    localparam logic [3:0] reg_lan_base = 4'h0;
    localparam logic [3:0] reg_lan_ctrl = 4'h4;
    localparam logic [3:0] reg_sata_base = 4'h8;
    localparam logic [3:0] reg_sata_ctrl = 4'hC;
    localparam logic [3:0] reg_last_route = 4'h0;
    localparam logic [4:0] reg_bank_shift = 5'h4;
    localparam logic [1:0] bank_ctrl = 2'h0;
    localparam logic [1:0] bank_bar = 2'h1;
    localparam logic [1:0] bank_stat = 2'h2;

    // ========================================
    // Reset values
    localparam logic [15:0] decode_enable_reset = 16'h0000;
    localparam logic [31:0] bar_reset = 32'h0000_0000;

    // ========================================
    // Field positions and window layout
    localparam int en_window_count = 7;
    localparam int en_high_first_bit = 8;
    localparam int en_low_count = 4;
    localparam logic [15:0] bios_hi_base = 16'hFFC0;
    localparam logic [15:0] bios_lo_base = 16'hFF80;
    localparam logic [15:0] legacy_hi_base = 16'hFF40;
    localparam logic [15:0] legacy_lo_base = 16'hFF00;
    localparam logic [11:0] patch_base = 12'hFEF;
    localparam logic [13:0] boot_top_base = 14'h3FFF;
    localparam logic [12:0] boot_fixed_hi = 13'h1FFF;
    localparam logic [12:0] boot_fixed_lo = 13'h1FF7;
    localparam logic [19:0] timer_base = 20'hFED00;
    localparam logic [16:0] trusted_base = 17'h1FDA8;
    localparam logic [17:0] fabric_err_base = 18'h3FB53;
    localparam logic [18:0] trace_base = 19'h7F6B0;
    localparam logic [15:0] engine_base = 16'hFED5;
    localparam int lan_size_bits = 17;
    localparam int sata_size_bits = 11;
    localparam logic [31:0] sata_min_base = 32'h0001_0000;
    localparam int swap_bit = 16;
    localparam logic [14:0] swap_region = 15'h7FFF;

    // ========================================
    // Targets
    typedef enum logic [3:0] {
        route_none,
        route_flash,
        route_engine,
        route_timer,
        route_trusted,
        route_fabric_err,
        route_trace,
        route_lan,
        route_sata
    } route_t;

    typedef enum logic [1:0] {
        resp_okay = 2'h0,
        resp_slverr = 2'h2,
        resp_decerr = 2'h3
    } resp_t;

endpackage
`default_nettype wire

// ===== logic/flash_window_match.sv
`default_nettype none
module flash_window_match (
    input wire logic [31:0] addr, // Cycle address
    input wire logic [15:0] decode_enable, // Firmware decode enables
    input wire logic microcode_patch_region_enable, // Patch window enable
    output logic hit // Flash window hit
);

    localparam int en_window_count = mem_decode_pkg::en_window_count;
    localparam int en_low_count = mem_decode_pkg::en_low_count;

    logic [en_window_count-1:0] hi_hit;
    logic [en_low_count-1:0] lo_hit;

    // ========================================
    // Enable-gated 512 KB pairs, bits 8..14
    genvar i;
    generate
        for (i = 0; i < en_window_count; i++)
        begin : g_hi
            logic [12:0] idx;
            assign idx = 13'(i) + mem_decode_pkg::bios_hi_base[15:3];
            assign hi_hit[i] =
                decode_enable[mem_decode_pkg::en_high_first_bit + i] &&
                (addr[31:19] == idx ||
                 addr[31:19] == 13'(i) +
                    mem_decode_pkg::bios_lo_base[15:3]);
        end
        // 1 MB pairs, bits 0..3
        for (i = 0; i < en_low_count; i++)
        begin : g_lo
            assign lo_hit[i] = decode_enable[i] &&
                (addr[31:20] == 12'(i) +
                    mem_decode_pkg::legacy_hi_base[15:4] ||
                 addr[31:20] == 12'(i) +
                    mem_decode_pkg::legacy_lo_base[15:4]);
        end
    endgenerate

    // Each window independent; unmatched cycles never hit
    assign hit = (|hi_hit) || (|lo_hit) ||
        (microcode_patch_region_enable &&
         addr[31:20] == mem_decode_pkg::patch_base) ||
        addr[31:18] == mem_decode_pkg::boot_top_base ||
        addr[31:19] == mem_decode_pkg::boot_fixed_hi ||
        addr[31:19] == mem_decode_pkg::boot_fixed_lo;

endmodule
`default_nettype wire

// ===== logic/firmware_memory_decoder.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
module firmware_memory_decoder (
    input wire logic clk, // 25 MHz clock
    input wire logic srst, // Synchronous reset, high
    // Avalon-MM register slave
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Wait request
    output logic [1:0] avs_response, // Response code
    // Upstream memory cycle
    input wire logic cyc_valid, // Cycle present, one pulse
    input wire logic [31:0] cyc_addr, // Cycle address
    input wire logic top_swap_strap, // Forces top swap
    output logic route_valid, // Routed cycle, one pulse
    output logic [3:0] route_target, // Target code
    output logic [31:0] route_addr, // Address after swap
    output logic master_abort // No target, one pulse
);

    // ========================================
    // State
    typedef struct packed {
        logic [15:0] decode_enable;
        logic patch_enable;
        logic [1:0] timer_select;
        logic top_swap;
        logic [31:0] lan_base;
        logic lan_en;
        logic [31:0] sata_base;
        logic sata_en;
        logic [3:0] last_target;
        logic [15:0] abort_count;
        logic [31:0] readdata;
        logic waitrequest;
        logic [1:0] response;
        logic ack;
        logic route_valid;
        logic [3:0] route_target;
        logic [31:0] route_addr;
        logic master_abort;
    } state_t;

    state_t state;
    state_t next_state;
    logic flash_hit;
    logic swap_on;
    mem_decode_pkg::route_t target;
    logic [31:0] swapped;

    // Merge bytes of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    flash_window_match u_flash (
        .addr(cyc_addr),
        .decode_enable(state.decode_enable),
        .microcode_patch_region_enable(state.patch_enable),
        .hit(flash_hit)
    );

    // ========================================
    // Target decode
    always_comb
    begin
        swap_on = state.top_swap || top_swap_strap;
        swapped = cyc_addr;
        // Exchange the two top 64 KB blocks
        if (swap_on && cyc_addr[31:17] == mem_decode_pkg::swap_region)
        begin
            swapped[mem_decode_pkg::swap_bit] =
                ~cyc_addr[mem_decode_pkg::swap_bit];
        end
        if (flash_hit)
        begin
            target = mem_decode_pkg::route_flash;
        end
        // Select digit sits in bits 15:12, window is the low 1 KB
        else if (cyc_addr[31:16] == mem_decode_pkg::timer_base[19:4] &&
            cyc_addr[15:10] == {2'h0, state.timer_select, 2'h0})
        begin
            target = mem_decode_pkg::route_timer;
        end
        else if (cyc_addr[31:15] == mem_decode_pkg::trusted_base)
        begin
            target = mem_decode_pkg::route_trusted;
        end
        else if (cyc_addr[31:14] == mem_decode_pkg::fabric_err_base)
        begin
            target = mem_decode_pkg::route_fabric_err;
        end
        else if (cyc_addr[31:13] == mem_decode_pkg::trace_base)
        begin
            target = mem_decode_pkg::route_trace;
        end
        else if (cyc_addr[31:16] == mem_decode_pkg::engine_base)
        begin
            target = mem_decode_pkg::route_engine;
        end
        else if (state.lan_en && cyc_addr[31:mem_decode_pkg::lan_size_bits]
            == state.lan_base[31:mem_decode_pkg::lan_size_bits])
        begin
            target = mem_decode_pkg::route_lan;
        end
        else if (state.sata_en &&
            state.sata_base >= mem_decode_pkg::sata_min_base &&
            cyc_addr[31:mem_decode_pkg::sata_size_bits] ==
            state.sata_base[31:mem_decode_pkg::sata_size_bits])
        begin
            target = mem_decode_pkg::route_sata;
        end
        else
        begin
            target = mem_decode_pkg::route_none;
        end
    end

    // ========================================
    // Next state
    always_comb
    begin
        logic [1:0] bank;
        logic [3:0] off;
        bank = avs_address[5:4];
        off = avs_address[3:0];
        next_state = state;
        next_state.route_valid = 1'b0;
        next_state.master_abort = 1'b0;
        next_state.ack = 1'b0;
        next_state.waitrequest = 1'b1;
        next_state.response = mem_decode_pkg::resp_okay;

        // Routing of an upstream cycle
        if (cyc_valid)
        begin
            next_state.route_target = target;
            next_state.route_addr = swapped;
            next_state.last_target = target;
            if (target == mem_decode_pkg::route_none)
            begin
                next_state.master_abort = 1'b1;
                next_state.abort_count = state.abort_count + 16'h0001;
            end
            else
            begin
                next_state.route_valid = 1'b1;
            end
        end

        // Register access, one wait cycle then answer
        if ((avs_read || avs_write) && !state.ack)
        begin
            next_state.ack = 1'b1;
            next_state.waitrequest = 1'b0;
            next_state.readdata = 32'h0000_0000;
            unique case (bank)
                mem_decode_pkg::bank_ctrl:
                begin
                    unique case (off)
                        mem_decode_pkg::reg_decode_enable:
                        begin
                            next_state.readdata[15:0] = state.decode_enable;
                            if (avs_write)
                            begin
                                next_state.decode_enable = 16'(merge(
                                    {16'h0000, state.decode_enable},
                                    avs_writedata, avs_byteenable));
                            end
                        end
                        mem_decode_pkg::reg_patch_enable:
                        begin
                            next_state.readdata[0] = state.patch_enable;
                            if (avs_write && avs_byteenable[0])
                            begin
                                next_state.patch_enable = avs_writedata[0];
                            end
                        end
                        mem_decode_pkg::reg_timer_select:
                        begin
                            next_state.readdata[1:0] = state.timer_select;
                            if (avs_write && avs_byteenable[0])
                            begin
                                next_state.timer_select =
                                    avs_writedata[1:0];
                            end
                        end
                        default:
                        begin
                            next_state.readdata[0] = swap_on;
                            next_state.readdata[1] = top_swap_strap;
                            if (avs_write && avs_byteenable[0])
                            begin
                                next_state.top_swap = avs_writedata[0];
                            end
                        end
                    endcase
                end
                mem_decode_pkg::bank_bar:
                begin
                    unique case (off)
                        mem_decode_pkg::reg_lan_base:
                        begin
                            next_state.readdata = state.lan_base;
                            if (avs_write)
                            begin
                                next_state.lan_base = merge(state.lan_base,
                                    avs_writedata, avs_byteenable);
                            end
                        end
                        mem_decode_pkg::reg_lan_ctrl:
                        begin
                            next_state.readdata[0] = state.lan_en;
                            if (avs_write && avs_byteenable[0])
                            begin
                                next_state.lan_en = avs_writedata[0];
                            end
                        end
                        mem_decode_pkg::reg_sata_base:
                        begin
                            next_state.readdata = state.sata_base;
                            if (avs_write)
                            begin
                                next_state.sata_base = merge(state.sata_base,
                                    avs_writedata, avs_byteenable);
                            end
                        end
                        default:
                        begin
                            next_state.readdata[0] = state.sata_en;
                            if (avs_write && avs_byteenable[0])
                            begin
                                next_state.sata_en = avs_writedata[0];
                            end
                        end
                    endcase
                end
                mem_decode_pkg::bank_stat:
                begin
                    if (off == mem_decode_pkg::reg_last_route)
                    begin
                        next_state.readdata = {12'h000, state.abort_count,
                            state.last_target};
                    end
                    else
                    begin
                        next_state.response = mem_decode_pkg::resp_decerr;
                    end
                end
                default:
                begin
                    next_state.response = mem_decode_pkg::resp_decerr;
                end
            endcase
        end

        if (srst)
        begin
            next_state = '0;
            next_state.decode_enable = mem_decode_pkg::decode_enable_reset;
            next_state.lan_base = mem_decode_pkg::bar_reset;
            next_state.sata_base = mem_decode_pkg::bar_reset;
            next_state.waitrequest = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        state <= next_state;
    end

    assign avs_readdata = state.readdata;
    assign avs_waitrequest = state.waitrequest;
    assign avs_response = state.response;
    assign route_valid = state.route_valid;
    assign route_target = state.route_target;
    assign route_addr = state.route_addr;
    assign master_abort = state.master_abort;

endmodule
`default_nettype wire

// ===== verification/firmware_memory_decoder_properties.sv
`default_nettype none
module decoder_checker (
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic cyc_valid, // Cycle in
    input wire logic [31:0] cyc_addr, // Cycle address
    input wire logic top_swap_strap, // Swap strap
    input wire logic route_valid, // Routed pulse
    input wire logic [3:0] route_target, // Target code
    input wire logic [31:0] route_addr, // Routed address
    input wire logic master_abort // Abort pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_answer;
        cyc_valid |=> route_valid ^ master_abort;
    endproperty
    a_answer: assert property (p_answer)
        else $error("cycle without exactly one answer");
    property p_quiet;
        !cyc_valid |=> !route_valid && !master_abort;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without a cycle");
    property p_top;
        cyc_valid && cyc_addr[31:18] == 14'h3FFF |=>
            route_valid && route_target == 4'h1;
    endproperty
    a_top: assert property (p_top)
        else $error("top block not sent to flash");
    property p_fixed;
        cyc_valid && (cyc_addr[31:19] == 13'h1FFF ||
            cyc_addr[31:19] == 13'h1FF7) |=> route_target == 4'h1;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed flash window missed");
    property p_engine;
        cyc_valid && cyc_addr[31:16] == 16'hFED5 |=>
            route_valid && route_target == 4'h2;
    endproperty
    a_engine: assert property (p_engine)
        else $error("engine window missed");
    property p_fabric;
        cyc_valid && cyc_addr[31:14] == 18'h3FB53 |=> route_target == 4'h5;
    endproperty
    a_fabric: assert property (p_fabric)
        else $error("fabric error window missed");
    property p_trace;
        cyc_valid && cyc_addr[31:13] == 19'h7F6B0 |=> route_target == 4'h6;
    endproperty
    a_trace: assert property (p_trace)
        else $error("trace window missed");
    property p_trusted;
        cyc_valid && cyc_addr[31:15] == 17'h1FDA8 |=> route_target == 4'h4;
    endproperty
    a_trusted: assert property (p_trusted)
        else $error("trusted module window missed");
    property p_addr;
        cyc_valid ##1 route_valid |->
            (route_addr & 32'hFFFE_FFFF) == ($past(cyc_addr) & 32'hFFFE_FFFF);
    endproperty
    a_addr: assert property (p_addr)
        else $error("routed address bits other than A16 changed");
    property p_strap;
        cyc_valid && top_swap_strap && cyc_addr[31:17] == 15'h7FFF |=>
            route_addr[16] != $past(cyc_addr[16]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap swap did not invert A16");
endmodule
bind firmware_memory_decoder decoder_checker u_checker (.clk, .srst,
    .cyc_valid, .cyc_addr, .top_swap_strap, .route_valid, .route_target,
    .route_addr, .master_abort);
`default_nettype wire

// ===== verification/host_cycle_model.sv
`default_nettype none
module host_cycle_model (
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic req, // Bench asks for a cycle
    input wire logic [31:0] req_addr, // Requested address
    output logic cyc_valid, // Cycle pulse
    output logic [31:0] cyc_addr // Cycle address
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle address toggles so a stale value is never trusted
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cyc_valid <= 1'b0;
            cyc_addr <= 32'h0000_0000;
        end
        else if (req && req_addr[31:13] != 19'h7F6B1)
        begin
            cyc_valid <= 1'b1;
            cyc_addr <= req_addr;
        end
        else
        begin
            cyc_valid <= 1'b0;
            cyc_addr <= ~cyc_addr;
        end
    end
endmodule
`default_nettype wire

// ===== verification/firmware_memory_decoder_bench.sv
`default_nettype none
module firmware_memory_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, route_addr, cyc_addr, q;
    logic [1:0] avs_response, rsp;
    logic avs_waitrequest, cyc_valid, route_valid, master_abort;
    logic [3:0] route_target, last_t;
    logic top_swap_strap = 1'b0;
    logic req = 1'b0;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [15:0] en = 16'h0000;
    logic [1:0] tsel = 2'h0;
    logic patch = 1'b0, swp = 1'b0, lane = 1'b0, satae = 1'b0;
    logic [31:0] lanb = 32'h0000_0000, satab = 32'h0000_0000, x;
    int errors = 0, check_count = 0, aborts = 0, seed = 14;
    logic [31:0] fix [12] = '{32'hFED4_0000, 32'hFED4_7FFF, 32'hFED4_8000,
        32'hFED4_C000, 32'hFED4_FFFF, 32'hFED6_0000, 32'hFED6_1FFF,
        32'hFED5_0000, 32'hFED5_FFFF, 32'hFEE0_0000, 32'hFFBF_FFFF,
        32'hFFFC_0000};

    always #20 clk = ~clk;

    firmware_memory_decoder DUT (.clk(clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
        .top_swap_strap(top_swap_strap), .route_valid(route_valid),
        .route_target(route_target), .route_addr(route_addr),
        .master_abort(master_abort));
    host_cycle_model host (.clk(clk), .srst(srst), .req(req),
        .req_addr(req_addr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr));

    // ========================================
    // Expectations
    function automatic logic [3:0] exp_t(input logic [31:0] a);
        if ((patch && a[31:20] == 12'hFEF)
            || (a[31:23] == 9'h1FF
                && (a[21:19] == 3'h7 || en[{1'b1, a[21:19]}]))
            || (a[31:23] == 9'h1FE && en[a[21:20]]))
            return 4'h1;
        if (a[31:16] == 16'hFED0 && a[15:12] == {2'h0, tsel}
            && !a[11] && !a[10])
            return 4'h3;
        if (a[31:15] == 17'h1FDA8) return 4'h4;
        if (a[31:14] == 18'h3FB53) return 4'h5;
        if (a[31:13] == 19'h7F6B0) return 4'h6;
        if (a[31:16] == 16'hFED5) return 4'h2;
        if (lane && a[31:17] == lanb[31:17]) return 4'h7;
        if (satae && satab >= 32'h0001_0000 && a[31:11] == satab[31:11])
            return 4'h8;
        return 4'h0;
    endfunction

    function automatic logic [31:0] win(input int j, input logic lo,
        input logic [31:0] r);
        logic [3:0] k;
        k = 4'(j);
        if (j < 4) return {8'hFF, 1'b0, ~lo, k[1:0], r[19:0]};
        return {9'h1FF, ~lo, 3'(k - 4'h8), r[18:0]};
    endfunction

    // ========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        check(rsp, 2'h0);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e,
        input logic [1:0] er);
        bus(1'b0, a, 32'h0000_0000);
        check(q, e);
        check(rsp, er);
    endtask

    task automatic cfg;
        wr(6'h00, {16'h0000, en});
        wr(6'h04, {31'h0, patch});
        wr(6'h08, {30'h0, tsel});
        wr(6'h0C, {31'h0, swp});
        wr(6'h10, lanb);
        wr(6'h14, {31'h0, lane});
        wr(6'h18, satab);
        wr(6'h1C, {31'h0, satae});
    endtask

    task automatic send(input logic [31:0] a);
        logic [3:0] t;
        if (a[31:13] == 19'h7F6B1) a[13] = 1'b0;
        t = exp_t(a);
        last_t = t;
        req <= 1'b1;
        req_addr <= a;
        @(posedge clk);
        req <= 1'b0;
        repeat (2) @(posedge clk);
        check(master_abort, t == 4'h0);
        check(route_valid, t != 4'h0);
        if (t != 4'h0)
        begin
            check(route_target, t);
            check(route_addr, ((swp | top_swap_strap) && a[31:17] == 15'h7FFF)
                ? a ^ 32'h0001_0000 : a);
        end
        else aborts++;
    endtask

    // ========================================
    // Sequence
    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        stop_test;
    end

    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 9; a++) rd(6'(a * 4), 32'h0, 2'h0);
        rd(6'h24, 32'h0, 2'h3);
        x = $random(seed);
        wr(6'h00, x);
        rd(6'h00, {16'h0000, x[15:0]}, 2'h0);
        $display("test registers done");
        for (int i = 0; i < 17; i++)
        begin
            en = 16'h1 << i;
            cfg;
            for (int j = 0; j < 16; j++)
                if (!(j inside {[4:7]}))
                begin
                    send(win(j, 1'b0, $random(seed)));
                    send(win(j, 1'b1, $random(seed)));
                end
        end
        $display("test flash windows done");
        en = 16'h0000;
        for (int p = 0; p < 2; p++)
        begin
            patch = p[0];
            cfg;
            x = $random(seed);
            send({12'hFEF, x[19:0]});
            send(32'hFEFF_FFFF);
        end
        patch = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            tsel = s[1:0];
            cfg;
            x = $random(seed);
            send({16'hFED0, 2'h0, tsel, 2'h0, x[9:0]});
            send({16'hFED0, 2'h0, tsel + 2'h1, 2'h0, x[9:0]});
            send({16'hFED0, 2'h0, tsel, 2'h1, x[9:0]});
        end
        foreach (fix[i]) send(fix[i]);
        bus(1'b0, 6'h20, 32'h0);
        check(q[3:0], last_t);
        check(q[19:4], aborts[15:0]);
        $display("test fixed windows done");
        for (int m = 0; m < 2; m++)
        begin
            swp = !m[0];
            top_swap_strap <= m[0];
            cfg;
            rd(6'h0C, {30'h0, m[0], 1'b1}, 2'h0);
            x = $random(seed);
            send({16'hFFFF, x[15:0]});
            send({16'hFFFE, x[15:0]});
            send({16'hFFFD, x[15:0]});
        end
        top_swap_strap <= 1'b0;
        swp = 1'b0;
        $display("test swap done");
        x = $random(seed);
        lanb = {1'b0, x[30:17], 17'h0};
        lane = 1'b1;
        satab = 32'h0000_F800;
        satae = 1'b1;
        cfg;
        send(lanb | {15'h0, x[16:0]});
        send(satab | {21'h0, x[10:0]});
        satab = {1'b0, x[30:11], 11'h0} | 32'h0001_0000;
        lane = 1'b0;
        cfg;
        send(satab | {21'h0, x[10:0]});
        send(lanb);
        $display("test base windows done");
        for (int k = 0; k < 200; k++)
        begin
            if (k % 50 == 0)
            begin
                x = $random(seed);
                {en, patch, tsel} = x[18:0];
                cfg;
            end
            x = $random(seed);
            send({7'h7F, x[24:0]});
        end
        for (int k = 0; k < 16; k++)
        begin
            req <= 1'b1;
            req_addr <= {7'h7F, 25'($random(seed))};
            @(posedge clk);
        end
        req <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test random done");
        stop_test;
    end
endmodule
`default_nettype wire
